// File: bench/cic_seq_model.sv
/*
 * Sequencer model: churns the live context, enters and leaves sleep,
 * issues return-from-interrupt and records the context seen at entry.
 * Assumes the bench drives sleep_req as a level and ret_req as a pulse.
 */
`default_nettype none

module cic_seq_model (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Bench commands
	input wire logic sleep_req,
	input wire logic ret_req,
	// Controller answers
	input wire logic irq_take,
	input wire logic wake,
	// Sequencer drive
	output logic sleep_active,
	output logic return_from_isr_instr_exec,
	output cic_pkg::cic_ctx_t ctx_live,
	// Context seen at entry
	output cic_pkg::cic_ctx_t ctx_saved
);
	timeunit 1ns;
	timeprecision 1ps;

	integer seed = 32'h0DA039E9;
	logic woke;

	// ------------------------------------------------------------
	// Sequencer behaviour
	// ------------------------------------------------------------
	// Context changes every clock so an early or late save shows up
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sleep_active <= 1'b0;
			return_from_isr_instr_exec <= 1'b0;
			ctx_live <= '0;
			ctx_saved <= '0;
			woke <= 1'b0;
		end else begin
			ctx_live <= cic_pkg::cic_ctx_t'({$random(seed), $random(seed)});
			return_from_isr_instr_exec <= ret_req;
			if (irq_take) begin
				ctx_saved <= ctx_live;
			end
			// Stays awake after a wake until the bench drops the request
			woke <= sleep_req & (woke | wake);
			sleep_active <= sleep_req & ~woke & ~wake;
		end
	end

endmodule

`default_nettype wire

// File: bench/core_interrupt_control_test.sv
/*
 * Self-checking bench for the core interrupt controller.
 * Assumes the design package and the sequencer model are compiled first.
 */
`default_nettype none

module core_interrupt_control_test;
	timeunit 1ns;
	timeprecision 1ps;

	logic mclk, rst_n, reg_wr, reg_rd, ext_pin, tmr0_overflow;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, periph_flags;
	logic pin_change_any, sleep_active, return_from_isr_instr_exec, q1_strobe, irq_take;
	logic wake, ctx_restore_vld, sleep_req, ret_req;
	logic [15:0] vector_addr;
	cic_pkg::cic_ctx_t ctx_live, ctx_restore, ctx_saved;
	int failures = 0;
	int cmp_count = 0;
	int cyc = 0;
	int n;
	int pbits[6] = '{7, 6, 5, 4, 1, 0};
	integer seed = 32'h0DA039E9;

	cic_core_irq_ctrl #(.ADDR_W(8)) dut_u (.mclk(mclk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_pin(ext_pin),
		.tmr0_overflow(tmr0_overflow), .pin_change_any(pin_change_any),
		.periph_flags(periph_flags), .sleep_active(sleep_active),
		.return_from_isr_instr_exec(return_from_isr_instr_exec), .ctx_live(ctx_live),
		.q1_strobe(q1_strobe), .irq_take(irq_take),
		.vector_addr(vector_addr), .wake(wake),
		.ctx_restore_vld(ctx_restore_vld), .ctx_restore(ctx_restore));

	cic_seq_model model_u (.mclk(mclk), .rst_n(rst_n),
		.sleep_req(sleep_req), .ret_req(ret_req), .irq_take(irq_take),
		.wake(wake), .sleep_active(sleep_active),
		.return_from_isr_instr_exec(return_from_isr_instr_exec), .ctx_live(ctx_live),
		.ctx_saved(ctx_saved));

	// ------------------------------------------------------------
	// Clock and hang guard
	// ------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	// Whole run needs about a thousand clocks; the ceiling leaves margin
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			final_report;
		end
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task final_report;
		$display("Comparisons %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task chkv(input logic [63:0] g, input logic [63:0] e, input string m);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
		end
	endtask

	// Cycle counts; -1 means the event never came
	task chkr(input int g, input int lo, input int hi, input string m);
		cmp_count++;
		if (g < lo || g > hi) begin
			failures++;
			$display("MISMATCH t=%0t %s count %0d", $time, m, g);
		end
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task rdc(input logic [7:0] a, input logic [7:0] e, input string m);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 chkv(64'(reg_rdata), 64'(e), m);
	endtask

	task pulse_tmr0;
		@(posedge mclk) tmr0_overflow <= 1'b1;
		@(posedge mclk) tmr0_overflow <= 1'b0;
	endtask

	// Which: 0 vector take, 1 wake, 2 restore valid
	task wait_for(input int which, input int lim, output int cnt);
		logic s;
		cnt = -1;
		for (int i = 1; i <= lim; i++) begin
			@(posedge mclk);
			#1;
			s = which == 0 ? irq_take : which == 1 ? wake : ctx_restore_vld;
			if (s === 1'b1) begin
				cnt = i;
				break;
			end
		end
	endtask

	// Check the entry, edit one shadow byte, return and check restore
	task service(input logic [7:0] en);
		logic [63:0] e;
		logic [7:0] d;
		int k;
		int c;
		chkv(64'(vector_addr), 64'(cic_pkg::IRQ_VECTOR), "vector");
		// The taken source's own flag stays set until the routine clears it
		rdc(cic_pkg::OFF_CORE_CTL, (en & 8'h78) | ((en >> 3) & 8'h06),
			"gie after take");
		e = ctx_saved;
		e[15:8] = e[15:8] & cic_pkg::STATUS_SAVE_MASK;
		for (k = 0; k < 8; k++) begin
			rdc(cic_pkg::OFF_SHADOW_BASE + 8'(k), e[8*k +: 8], "shadow");
		end
		k = {$random(seed)} % 8;
		d = 8'($random(seed));
		if (k == 1)
			d = d & cic_pkg::STATUS_SAVE_MASK;
		wr(cic_pkg::OFF_SHADOW_BASE + 8'(k), d);
		e[8*k +: 8] = d;
		wr(cic_pkg::OFF_CORE_CTL, en);
		@(posedge mclk) ret_req <= 1'b1;
		@(posedge mclk) ret_req <= 1'b0;
		wait_for(2, 4, c);
		chkr(c, 1, 3, "restore valid");
		chkv(ctx_restore, e, "restored context");
		rdc(cic_pkg::OFF_CORE_CTL, en | 8'h80, "gie after return");
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		ext_pin = 1'b0;
		tmr0_overflow = 1'b0;
		pin_change_any = 1'b0;
		periph_flags = 8'h00;
		sleep_req = 1'b0;
		ret_req = 1'b0;
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		// Reset values, register layout and an unmapped read
		rdc(cic_pkg::OFF_CORE_CTL, 8'h00, "core reset");
		rdc(cic_pkg::OFF_PERIPH_IRQ_ENABLE_1, 8'h00, "periph_irq_enable_1 reset");
		rdc(cic_pkg::OFF_EDGE_CFG, 8'h01, "edge reset");
		rdc(8'h05, 8'h00, "unmapped");
		wr(cic_pkg::OFF_PERIPH_IRQ_ENABLE_1, 8'hFF);
		rdc(cic_pkg::OFF_PERIPH_IRQ_ENABLE_1, 8'hF3, "periph_irq_enable_1 bits");
		wr(cic_pkg::OFF_CORE_CTL, 8'h78);
		rdc(cic_pkg::OFF_CORE_CTL, 8'h78, "enables");
		wr(cic_pkg::OFF_PERIPH_IRQ_ENABLE_1, 8'h00);
		wr(cic_pkg::OFF_CORE_CTL, 8'h00);
		// Flags rise with every enable off; summary flag ignores writes
		pulse_tmr0;
		rdc(cic_pkg::OFF_CORE_CTL, 8'h04, "timer0 flag");
		@(posedge mclk) pin_change_any <= 1'b1;
		wr(cic_pkg::OFF_CORE_CTL, 8'h00);
		rdc(cic_pkg::OFF_CORE_CTL, 8'h01, "summary flag");
		@(posedge mclk) pin_change_any <= 1'b0;
		rdc(cic_pkg::OFF_CORE_CTL, 8'h00, "summary clear");
		// Both edge selections against both pin directions
		for (int es = 1; es >= 0; es--) begin
			wr(cic_pkg::OFF_EDGE_CFG, 8'(es));
			for (int s = 0; s < 2; s++) begin
				@(posedge mclk) ext_pin <= ~ext_pin;
				repeat (10) @(posedge mclk);
				rdc(cic_pkg::OFF_CORE_CTL, (ext_pin == es[0]) ? 8'h02 : 8'h00,
					"pin edge");
				wr(cic_pkg::OFF_CORE_CTL, 8'h00);
			end
		end
		// Synchronous source latency and context round trip
		wr(cic_pkg::OFF_CORE_CTL, 8'hA0);
		pulse_tmr0;
		wait_for(0, 24, n);
		chkr(n, 1, 16, "timer0 latency");
		service(8'h20);
		// Asynchronous pin latency
		wr(cic_pkg::OFF_EDGE_CFG, 8'h01);
		wr(cic_pkg::OFF_CORE_CTL, 8'h90);
		@(posedge mclk) ext_pin <= 1'b1;
		wait_for(0, 24, n);
		chkr(n, 1, 20, "pin latency");
		service(8'h10);
		wr(cic_pkg::OFF_CORE_CTL, 8'h00);
		@(posedge mclk) ext_pin <= 1'b0;
		// Each peripheral enable needs both global bits
		for (int i = 0; i < 6; i++) begin
			wr(cic_pkg::OFF_PERIPH_IRQ_ENABLE_1, 8'h01 << pbits[i]);
			@(posedge mclk) periph_flags <= 8'h01 << pbits[i];
			wr(cic_pkg::OFF_CORE_CTL, 8'h40);
			wait_for(0, 24, n);
			chkr(n, -1, -1, "global off");
			wr(cic_pkg::OFF_CORE_CTL, 8'h80);
			wait_for(0, 24, n);
			chkr(n, -1, -1, "gate off");
			wr(cic_pkg::OFF_CORE_CTL, 8'hC0);
			wait_for(0, 24, n);
			chkr(n, 1, 16, "peripheral take");
			@(posedge mclk) periph_flags <= 8'h00;
			service(8'h40);
			wr(cic_pkg::OFF_CORE_CTL, 8'h00);
		end
		// Wake without global enable carries on, no vector
		wr(cic_pkg::OFF_CORE_CTL, 8'h20);
		@(posedge mclk) sleep_req <= 1'b1;
		repeat (2) @(posedge mclk);
		pulse_tmr0;
		wait_for(1, 4, n);
		chkr(n, 1, 3, "wake");
		wait_for(0, 24, n);
		chkr(n, -1, -1, "no vector");
		@(posedge mclk) sleep_req <= 1'b0;
		wr(cic_pkg::OFF_CORE_CTL, 8'h00);
		// Enable set only after sleep began does not wake
		@(posedge mclk) sleep_req <= 1'b1;
		repeat (2) @(posedge mclk);
		wr(cic_pkg::OFF_CORE_CTL, 8'h20);
		pulse_tmr0;
		wait_for(1, 16, n);
		chkr(n, -1, -1, "late enable");
		@(posedge mclk) sleep_req <= 1'b0;
		wr(cic_pkg::OFF_CORE_CTL, 8'h00);
		// Wake with global enable: one instruction, then the vector
		wr(cic_pkg::OFF_CORE_CTL, 8'hA0);
		@(posedge mclk) sleep_req <= 1'b1;
		repeat (2) @(posedge mclk);
		pulse_tmr0;
		wait_for(1, 4, n);
		chkr(n, 1, 3, "wake");
		wait_for(0, 20, n);
		chkr(n, 4, 16, "vector after wake");
		@(posedge mclk) sleep_req <= 1'b0;
		service(8'h20);
		final_report;
	end

endmodule

`default_nettype wire

// File: design/cic_core_irq_ctrl.sv
/*
 * Core interrupt controller: control and first peripheral enable
 * registers, external pin edge detect, latency sequencing, sleep wake,
 * and shadow save and restore of the core context.
 * Assumes a sequencer on mclk that follows the phase strobe, the peripheral
 * flag levels come from the same clock, and the external pin is async.
 */
// Local design decisions: the placing of the registers and the strobed register port.
`default_nettype none

module cic_core_irq_ctrl #(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Interrupt sources
	input wire logic ext_pin,
	input wire logic tmr0_overflow,
	input wire logic pin_change_any,
	input wire logic [7:0] periph_flags,
	// Processor sequencer
	input wire logic sleep_active,
	input wire logic return_from_isr_instr_exec,
	input wire cic_pkg::cic_ctx_t ctx_live,
	output logic q1_strobe,
	output logic irq_take,
	output logic [15:0] vector_addr,
	output logic wake,
	output logic ctx_restore_vld,
	output cic_pkg::cic_ctx_t ctx_restore
);

	// ----------------------------------------------------------------
	// Parameter check
	// ----------------------------------------------------------------
	if (ADDR_W < 5 || ADDR_W > 8) begin : g_bad_addr
		$error("ADDR_W must lie between 5 and 8");
	end

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	cic_pkg::cic_phase_t q_r;
	cic_pkg::cic_state_t st_r;
	cic_pkg::cic_state_t st_nxt;
	cic_pkg::cic_ctx_t shd_r;
	logic [7:0] ctl_r;
	logic [7:0] periph_irq_enable_1_r;
	logic edge_sel_r;
	logic ext_meta_r;
	logic ext_sync_r;
	logic ext_prev_r;
	logic edge_pend_r;
	logic edge_hit;
	logic q_flag_ok;
	logic set_ext_flag;
	logic [7:0] en_snap_r;
	logic [7:0] pie_snap_r;
	logic sleep_prev_r;
	logic wake_r;
	logic restore_r;
	logic [15:0] vec_r;
	logic [7:0] rdata_r;
	logic periph_req;
	logic irq_pending;
	logic irq_req;
	logic wake_req;
	logic wr_ctl;
	logic wr_periph_irq_enable_1;
	logic wr_edge;
	logic wr_shd;
	logic [2:0] shd_idx;
	logic [7:0] rd_mux;

	assign q1_strobe = (q_r == cic_pkg::CIC_Q1);
	assign irq_take = (st_r == cic_pkg::CIC_TAKE);
	assign vector_addr = vec_r;
	assign wake = wake_r;
	assign ctx_restore_vld = restore_r;
	assign ctx_restore = shd_r;
	assign reg_rdata = rdata_r;

	// ----------------------------------------------------------------
	// Instruction cycle phase counter
	// ----------------------------------------------------------------
	// Q1..Q4 each last one clock; one pass is one instruction cycle
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			q_r <= cic_pkg::CIC_Q1;
		end else begin
			q_r <= cic_pkg::cic_phase_t'(q_r + 2'h1);
		end
	end

	// ----------------------------------------------------------------
	// Register address decode
	// ----------------------------------------------------------------
	always_comb begin
		wr_ctl = 1'b0;
		wr_periph_irq_enable_1 = 1'b0;
		wr_edge = 1'b0;
		wr_shd = 1'b0;
		if (reg_wr && reg_addr == cic_pkg::OFF_CORE_CTL[ADDR_W-1:0]) begin
			wr_ctl = 1'b1;
		end else if (reg_wr && reg_addr == cic_pkg::OFF_PERIPH_IRQ_ENABLE_1[ADDR_W-1:0]) begin
			wr_periph_irq_enable_1 = 1'b1;
		end else if (reg_wr &&
				reg_addr == cic_pkg::OFF_EDGE_CFG[ADDR_W-1:0]) begin
			wr_edge = 1'b1;
		end else if (reg_wr && reg_addr[ADDR_W-1:3] ==
				cic_pkg::OFF_SHADOW_BASE[ADDR_W-1:3]) begin
			wr_shd = 1'b1;
		end
	end
	assign shd_idx = reg_addr[2:0];

	// ----------------------------------------------------------------
	// External pin synchroniser and edge detector
	// ----------------------------------------------------------------
	// Two flops before the detector; only the second is looked at
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ext_meta_r <= 1'b0;
			ext_sync_r <= 1'b0;
			ext_prev_r <= 1'b0;
		end else begin
			ext_meta_r <= ext_pin;
			ext_sync_r <= ext_meta_r;
			ext_prev_r <= ext_sync_r;
		end
	end

	// Selected edge polarity
	assign edge_hit = edge_sel_r ? (ext_sync_r && !ext_prev_r) :
		(!ext_sync_r && ext_prev_r);
	// The flag may only move in the Q4-Q1 window
	assign q_flag_ok = (q_r == cic_pkg::CIC_Q4) || (q_r == cic_pkg::CIC_Q1);
	assign set_ext_flag = (edge_hit || edge_pend_r) && q_flag_ok;

	// An edge outside the window waits here for the next Q4
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			edge_pend_r <= 1'b0;
		end else if (set_ext_flag) begin
			edge_pend_r <= 1'b0;
		end else if (edge_hit) begin
			edge_pend_r <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Core control register
	// ----------------------------------------------------------------
	// Hardware sets win over a software clear in the same cycle
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctl_r <= cic_pkg::CORE_CTL_RST;
		end else begin
			if (wr_ctl) begin
				ctl_r[7:1] <= reg_wdata[7:1];
			end
			if (irq_take) begin
				ctl_r[cic_pkg::BIT_GIE] <= 1'b0;
			end else if (return_from_isr_instr_exec) begin
				ctl_r[cic_pkg::BIT_GIE] <= 1'b1;
			end
			if (tmr0_overflow) begin
				ctl_r[cic_pkg::BIT_TMR0_FLAG] <= 1'b1;
			end
			if (set_ext_flag) begin
				ctl_r[cic_pkg::BIT_EXT_FLAG] <= 1'b1;
			end
			// Summary flag mirrors the OR of the per-pin flags
			ctl_r[cic_pkg::BIT_PCHG_FLAG] <= pin_change_any;
		end
	end

	// ----------------------------------------------------------------
	// Peripheral enable and edge select registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			periph_irq_enable_1_r <= cic_pkg::PERIPH_IRQ_ENABLE_1_RST;
		end else if (wr_periph_irq_enable_1) begin
			periph_irq_enable_1_r <= reg_wdata & cic_pkg::PERIPH_IRQ_ENABLE_1_WR_MASK;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			edge_sel_r <= cic_pkg::EDGE_SEL_RST;
		end else if (wr_edge) begin
			edge_sel_r <= reg_wdata[cic_pkg::BIT_EDGE_SEL];
		end
	end

	// ----------------------------------------------------------------
	// Request combining
	// ----------------------------------------------------------------
	// Peripheral requests need both their own enable and the gate bit
	assign periph_req = ctl_r[cic_pkg::BIT_PERIPHERAL_IRQ_GATE] &&
		|(periph_flags & periph_irq_enable_1_r);
	assign irq_pending =
		(ctl_r[cic_pkg::BIT_TMR0_EN] && ctl_r[cic_pkg::BIT_TMR0_FLAG]) ||
		(ctl_r[cic_pkg::BIT_EXT_EN] && ctl_r[cic_pkg::BIT_EXT_FLAG]) ||
		(ctl_r[cic_pkg::BIT_PCHG_EN] && ctl_r[cic_pkg::BIT_PCHG_FLAG]) ||
		periph_req;
	assign irq_req = ctl_r[cic_pkg::BIT_GIE] && irq_pending;

	// ----------------------------------------------------------------
	// Sleep wake
	// ----------------------------------------------------------------
	// Enables are frozen as sleep begins; later writes cannot wake us
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sleep_prev_r <= 1'b0;
			en_snap_r <= 8'h00;
			pie_snap_r <= 8'h00;
		end else begin
			sleep_prev_r <= sleep_active;
			if (sleep_active && !sleep_prev_r) begin
				en_snap_r <= ctl_r;
				pie_snap_r <= periph_irq_enable_1_r;
			end
		end
	end

	// Wake ignores the global enable; that only picks vector or not
	assign wake_req = sleep_active && sleep_prev_r && (
		(en_snap_r[cic_pkg::BIT_TMR0_EN] && ctl_r[cic_pkg::BIT_TMR0_FLAG]) ||
		(en_snap_r[cic_pkg::BIT_EXT_EN] && ctl_r[cic_pkg::BIT_EXT_FLAG]) ||
		(en_snap_r[cic_pkg::BIT_PCHG_EN] && ctl_r[cic_pkg::BIT_PCHG_FLAG]) ||
		(en_snap_r[cic_pkg::BIT_PERIPHERAL_IRQ_GATE] &&
			|(periph_flags & pie_snap_r)));

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wake_r <= 1'b0;
		end else begin
			wake_r <= wake_req && !wake_r && st_r != cic_pkg::CIC_WAKE;
		end
	end

	// ----------------------------------------------------------------
	// Entry sequencer
	// ----------------------------------------------------------------
	// Sample at Q1, hold through the next full cycle, take at its Q4;
	// fixed steps keep the latency the same for 1- and 2-cycle opcodes
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			cic_pkg::CIC_IDLE: begin
				if (wake_r) begin
					st_nxt = cic_pkg::CIC_WAKE;
				end else if (q1_strobe && irq_req && !sleep_active) begin
					st_nxt = cic_pkg::CIC_SAMP;
				end
			end
			cic_pkg::CIC_SAMP: begin
				if (q_r == cic_pkg::CIC_Q4) begin
					st_nxt = cic_pkg::CIC_HOLD;
				end
			end
			cic_pkg::CIC_HOLD: begin
				if (q_r == cic_pkg::CIC_Q4) begin
					st_nxt = irq_req ? cic_pkg::CIC_TAKE :
						cic_pkg::CIC_IDLE;
				end
			end
			cic_pkg::CIC_TAKE: begin
				st_nxt = cic_pkg::CIC_IDLE;
			end
			cic_pkg::CIC_WAKE: begin
				// The instruction after sleep runs during hold
				if (q1_strobe) begin
					st_nxt = cic_pkg::CIC_HOLD;
				end
			end
			default: begin
				st_nxt = cic_pkg::CIC_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= cic_pkg::CIC_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Vector address is held in a flop for the sequencer to load
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			vec_r <= cic_pkg::IRQ_VECTOR;
		end else begin
			vec_r <= cic_pkg::IRQ_VECTOR;
		end
	end

	// ----------------------------------------------------------------
	// Shadow context
	// ----------------------------------------------------------------
	// Entry save beats a software write landing in the same cycle
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			shd_r <= '0;
		end else if (irq_take) begin
			shd_r <= ctx_live;
			shd_r.status <= ctx_live.status &
				cic_pkg::STATUS_SAVE_MASK;
		end else if (wr_shd) begin
			shd_r[shd_idx*8 +: 8] <= reg_wdata;
		end
	end

	// Restore strobe: one clock after the return opcode executes
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			restore_r <= 1'b0;
		end else begin
			restore_r <= return_from_isr_instr_exec;
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	always_comb begin
		rd_mux = 8'h00;
		if (reg_addr == cic_pkg::OFF_CORE_CTL[ADDR_W-1:0]) begin
			rd_mux = ctl_r;
		end else if (reg_addr == cic_pkg::OFF_PERIPH_IRQ_ENABLE_1[ADDR_W-1:0]) begin
			rd_mux = periph_irq_enable_1_r;
		end else if (reg_addr == cic_pkg::OFF_EDGE_CFG[ADDR_W-1:0]) begin
			rd_mux = {7'h00, edge_sel_r};
		end else if (reg_addr ==
				cic_pkg::OFF_CTRL_STATE[ADDR_W-1:0]) begin
			rd_mux = {4'h0, edge_pend_r, st_r};
		end else if (reg_addr[ADDR_W-1:3] ==
				cic_pkg::OFF_SHADOW_BASE[ADDR_W-1:3]) begin
			rd_mux = shd_r[shd_idx*8 +: 8];
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= 8'h00;
		end else begin
			rdata_r <= reg_rd ? rd_mux : 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence s_sampled;
		st_r == cic_pkg::CIC_IDLE && q1_strobe && irq_req && !sleep_active
			&& !wake_r;
	endsequence

	sequence s_sample_walk;
		(st_r == cic_pkg::CIC_SAMP)[*3] ##1 st_r == cic_pkg::CIC_HOLD;
	endsequence

	a_sample_timing: assert property (s_sampled |=> s_sample_walk)
		else $error("sample to hold did not take three clocks");

	a_take_clears_gie: assert property (
		irq_take |=> !ctl_r[cic_pkg::BIT_GIE] && !irq_take)
		else $error("entry did not clear the global enable");

	a_take_at_q4: assert property (
		irq_take |-> $past(q_r) == cic_pkg::CIC_Q4 && q1_strobe)
		else $error("entry not aligned to cycle boundary");

	a_save_context: assert property (
		irq_take |=> shd_r.w == $past(ctx_live.w) &&
			shd_r.status == ($past(ctx_live.status) &
			cic_pkg::STATUS_SAVE_MASK))
		else $error("shadow not loaded on entry");

	a_return_restore: assert property (
		return_from_isr_instr_exec && !irq_take |=> ctx_restore_vld &&
			ctl_r[cic_pkg::BIT_GIE])
		else $error("return did not restore or re-enable");

	a_flag_window: assert property (
		$rose(ctl_r[cic_pkg::BIT_EXT_FLAG]) |->
			$past(q_r) == cic_pkg::CIC_Q4 || $past(q_r) == cic_pkg::CIC_Q1)
		else $error("pin flag set outside the Q4-Q1 window");

	a_edge_sets_flag: assert property (
		edge_hit |-> ##[0:3] ctl_r[cic_pkg::BIT_EXT_FLAG] ##0 1'b1
			or ##[1:4] ctl_r[cic_pkg::BIT_EXT_FLAG])
		else $error("selected edge did not set the pin flag");

	a_periph_irq_enable_1_reserved: assert property (
		periph_irq_enable_1_r[3:2] == 2'h0)
		else $error("reserved enable bits became set");

	a_summary_follows: assert property (
		ctl_r[cic_pkg::BIT_PCHG_FLAG] == $past(pin_change_any))
		else $error("summary flag does not follow its sources");

	a_wake_to_hold: assert property (
		wake_r && st_r == cic_pkg::CIC_IDLE |=> ##[0:4]
			st_r == cic_pkg::CIC_HOLD)
		else $error("wake did not run the next instruction first");

	a_no_take_disabled: assert property (
		irq_take |-> $past(ctl_r[cic_pkg::BIT_GIE]))
		else $error("entry taken with the global enable clear");

endmodule

`default_nettype wire

// File: design/cic_pkg.sv
/*
 * Package for the core interrupt controller: register map, bit positions,
 * reset values, phase and state encodings and the saved-context carrier.
 * Assumes one 40 MHz clock with four clocks to each instruction cycle.
 */
`default_nettype none

package cic_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam int PHASES_PER_TCY = 4;
	localparam logic [15:0] IRQ_VECTOR = 16'h0004;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_CORE_CTL = 8'h00;
	localparam logic [7:0] OFF_PERIPH_IRQ_ENABLE_1 = 8'h01;
	localparam logic [7:0] OFF_EDGE_CFG = 8'h02;
	localparam logic [7:0] OFF_CTRL_STATE = 8'h03;
	localparam logic [7:0] OFF_SHADOW_BASE = 8'h10;
	localparam int SHADOW_BYTES = 8;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int BIT_GIE = 7;
	localparam int BIT_PERIPHERAL_IRQ_GATE = 6;
	localparam int BIT_TMR0_EN = 5;
	localparam int BIT_EXT_EN = 4;
	localparam int BIT_PCHG_EN = 3;
	localparam int BIT_TMR0_FLAG = 2;
	localparam int BIT_EXT_FLAG = 1;
	localparam int BIT_PCHG_FLAG = 0;
	localparam int BIT_EDGE_SEL = 0;
	localparam logic [7:0] PERIPH_IRQ_ENABLE_1_WR_MASK = 8'hF3;
	localparam logic [7:0] STATUS_SAVE_MASK = 8'hE7;
	localparam logic [7:0] CORE_CTL_RST = 8'h00;
	localparam logic [7:0] PERIPH_IRQ_ENABLE_1_RST = 8'h00;
	localparam logic EDGE_SEL_RST = 1'b1;

	// ----------------------------------------------------------------
	// Encodings
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CIC_Q1 = 2'h0,
		CIC_Q2 = 2'h1,
		CIC_Q3 = 2'h2,
		CIC_Q4 = 2'h3
	} cic_phase_t;

	// Gray along idle, sample, hold, take; wake branches off hold
	typedef enum logic [2:0] {
		CIC_IDLE = 3'h0,
		CIC_SAMP = 3'h1,
		CIC_HOLD = 3'h3,
		CIC_TAKE = 3'h2,
		CIC_WAKE = 3'h7
	} cic_state_t;

	// Saved context, one byte per field, byte 0 (w) last
	typedef struct packed {
		logic [7:0] pc_high_latch;
		logic [7:0] fsr1_hi;
		logic [7:0] fsr1_lo;
		logic [7:0] fsr0_hi;
		logic [7:0] fsr0_lo;
		logic [7:0] bank_select_reg;
		logic [7:0] status;
		logic [7:0] w;
	} cic_ctx_t;

endpackage

`default_nettype wire
